// file: common/target_status_pkg.sv
package target_status_pkg;

  // Outcome of decoding a host command
  typedef enum logic [3:0] {
    CLS_RECV_CMD = 4'b0001,
    CLS_RECV_MSG = 4'b0010,
    CLS_FORWARD  = 4'b0100,
    CLS_REJECT   = 4'b1000
  } cmd_class_type;

  // Receive sequencer states
  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_START   = 5'b00010,
    ST_XFER    = 5'b00100,
    ST_DONE    = 5'b01000,
    ST_AUTOMSG = 5'b10000
  } rx_state_type;

endpackage

// file: common/target_status_regs.svh
`ifndef TARGET_STATUS_REGS_SVH
`define TARGET_STATUS_REGS_SVH

// ----------------------------------------
// Interrupt codes
// ----------------------------------------
`define CODE_BUS_RESET 8'h01
`define CODE_HS_TIMEOUT 8'h2c
`define CODE_SCSI_PARITY 8'h24
`define CODE_DONE 8'h60
`define CODE_DONE_ATN 8'h61
`define CODE_DONE_ATN_MSG 8'h62
`define CODE_CMD_DEFERRED 8'h64
`define CODE_CMD_REJECT 8'h65
`define CODE_REG_PARITY 8'h66

// ----------------------------------------
// Step values
// ----------------------------------------
`define STEP_BEFORE 8'h00
`define STEP_DURING 8'h01
`define STEP_AFTER 8'h02

// ----------------------------------------
// Command codes
// ----------------------------------------
`define CMD_RESELECT 8'h10
`define CMD_RECV_CMD 8'h14
`define CMD_RECV_MSG 8'h15
`define CMD_SEND_MSG 8'h16
`define CMD_DISCONNECT 8'h18
`define CMD_INIT_NIBBLE 4'h2

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define RESET_BYTE 8'h00
`define CLK_PERIOD_NS 10
`define TIMEOUT_TICK_NS 1000

`endif

// file: rtl/cmd_classifier.sv
`include "target_status_regs.svh"

module cmd_classifier
  import target_status_pkg::*;
(
  input wire logic [7:0] cmdCode,
  input wire logic isTarget,
  input wire logic nexusValid,
  output cmd_class_type cmdClass
);

  // Undefined and initiator codes first, then nexus legality
  always_comb begin
    cmdClass = CLS_REJECT;
    if (cmdCode[7:4] == `CMD_INIT_NIBBLE) begin
      cmdClass = isTarget ? CLS_REJECT : CLS_FORWARD;
    end else begin
      case (cmdCode)
        `CMD_RECV_CMD: cmdClass = nexusValid ? CLS_RECV_CMD : CLS_REJECT;
        `CMD_RECV_MSG: cmdClass = nexusValid ? CLS_RECV_MSG : CLS_REJECT;
        `CMD_SEND_MSG: cmdClass = nexusValid ? CLS_FORWARD : CLS_REJECT;
        `CMD_DISCONNECT: cmdClass = nexusValid ? CLS_FORWARD : CLS_REJECT;
        `CMD_RESELECT: cmdClass = nexusValid ? CLS_REJECT : CLS_FORWARD;
        default: cmdClass = CLS_REJECT;
      endcase
    end
  end

endmodule

// file: rtl/report_queue.sv
module report_queue
  import target_status_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rstnInt,
  input wire logic push,
  input wire logic [WIDTH-1:0] pushData,
  input wire logic pop,
  output logic [WIDTH-1:0] headData,
  output logic notEmpty,
  output logic full
);

  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("report_queue: DEPTH must be a power of two, at least 4");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;

  assign notEmpty = (count_q != '0);
  assign full = (count_q == (AW+1)'(DEPTH));
  assign headData = mem[rdPtr_q];

  // Storage; a push into a full queue is dropped
  always_ff @(posedge clk) begin
    if (push && !full) begin
      mem[wrPtr_q] <= pushData;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push && !full) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop && notEmpty) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push && !full) - (AW+1)'(pop && notEmpty);
    end
  end

endmodule

// file: rtl/target_receive_status_reporter.sv
// Contract
// R1: Bus reset gives code 01h, step 00h before, 01h during, 02h after transfer.
// R2: Handshake timeout ends the receive at once with 2Ch step 01h.
// R3: SCSI input parity error ends the receive at once with 24h step 01h.
// R4: Normal completion without attention reports 60h step 02h.
// R5: Command receive done, attention, auto message off: report 61h step 02h.
// R6: Command receive done, attention, auto message on: take one byte, 62h step 02h.
// R7: Message receive done with attention reports 61h step 02h in either mode.
// R8: Receive started with zero byte count: no transfer, report 65h step 01h.
// R9: Command during execution: earlier result first, then 64h step 00h.
// R10: Command while ready-state cause pending: that cause first, then 64h step 00h.
// R11: Undefined or initiator command while target is rejected with 65h step 00h.
// R12: Transfer without nexus, or reselection with nexus, rejected 65h step 00h.
// R13: Host register parity error reports 66h step 00h, command not run.
// R14: Each report raises the interrupt and holds until acknowledged; later ones queue.
`include "target_status_regs.svh"

module target_receive_status_reporter
  import target_status_pkg::*;
#(
  parameter int QUEUE_DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic cmdValid,
  input wire logic [7:0] cmdCode,
  input wire logic cmdParityErr,
  input wire logic isTarget,
  input wire logic nexusValid,
  input wire logic [7:0] transferByteCount,
  input wire logic autoMsgMode,
  input wire logic [7:0] timeoutLimit,
  input wire logic busReset,
  input wire logic atnAsserted,
  input wire logic byteStrobe,
  input wire logic byteParityErr,
  input wire logic readyCause,
  input wire logic [7:0] readyCauseCode,
  input wire logic [7:0] readyCauseStep,
  input wire logic intAck,
  output logic intReq,
  output logic [7:0] intCode,
  output logic [7:0] intStep,
  output logic rxActive,
  output logic forwardValid,
  output logic [7:0] forwardCode
);

  localparam int TICK_CYCLES = (`TIMEOUT_TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  initial begin
    if (QUEUE_DEPTH < 4) begin
      $error("target_receive_status_reporter: QUEUE_DEPTH below 4");
    end
  end

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rstSync_q;
  logic rstnInt;

  // Asynchronous assert, release after two edges
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rstSync_q <= 2'b00;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstnInt = rstSync_q[1];

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  rx_state_type state_q;
  cmd_class_type cmdClass;
  logic isCmd_q;
  logic [7:0] cnt_q;
  logic [6:0] tickCnt_q;
  logic tick;
  logic [7:0] toCnt_q;
  logic timeoutHit;
  logic resPush;
  logic [7:0] resCode;
  logic [7:0] resStep;
  logic pending;
  logic cmdDefer;
  logic defer64_q;
  logic push64;
  logic readyHold_q;
  logic [15:0] readyHoldData_q;
  logic readyPushNow;
  logic pushValid;
  logic [15:0] pushData;
  logic [15:0] headData;
  logic qNotEmpty;
  logic intReq_q;
  logic [7:0] intCode_q;
  logic [7:0] intStep_q;
  logic rxActive_q;
  logic forwardValid_q;
  logic [7:0] forwardCode_q;

  cmd_classifier u_classifier (
    .cmdCode(cmdCode),
    .isTarget(isTarget),
    .nexusValid(nexusValid),
    .cmdClass(cmdClass)
  );

  // ----------------------------------------
  // Handshake timeout
  // ----------------------------------------
  // Microsecond tick keeps the timeout counter only eight bits wide
  always_ff @(posedge sys_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      tickCnt_q <= '0;
    end else if (tickCnt_q == 7'(TICK_CYCLES - 1)) begin
      tickCnt_q <= '0;
    end else begin
      tickCnt_q <= tickCnt_q + 7'h01;
    end
  end
  assign tick = (tickCnt_q == 7'(TICK_CYCLES - 1));

  // Restarts on every byte; a zero limit disables the check
  always_ff @(posedge sys_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      toCnt_q <= `RESET_BYTE;
    end else if (!(state_q == ST_XFER || state_q == ST_AUTOMSG) || byteStrobe) begin
      toCnt_q <= `RESET_BYTE;
    end else if (tick && !timeoutHit) begin
      toCnt_q <= toCnt_q + 8'h01;
    end
  end
  assign timeoutHit = (timeoutLimit != 8'h00) && (toCnt_q == timeoutLimit); // R2

  // ----------------------------------------
  // Result of the running command
  // ----------------------------------------
  // A new command is not run, only reported as deferred, while anything is running or unreported
  assign pending = intReq_q || qNotEmpty || readyHold_q || readyCause; // R10
  assign cmdDefer = cmdValid && (state_q != ST_IDLE || pending); // R9

  // Bus reset outranks timeout, which outranks parity
  always_comb begin
    resPush = 1'b0;
    resCode = `RESET_BYTE;
    resStep = `RESET_BYTE;
    case (state_q)
      ST_IDLE: begin
        if (cmdValid && !cmdDefer && cmdParityErr) begin
          resPush = 1'b1; // R13
          resCode = `CODE_REG_PARITY;
          resStep = `STEP_BEFORE;
        end else if (cmdValid && !cmdDefer && cmdClass == CLS_REJECT) begin
          resPush = 1'b1; // R11 R12
          resCode = `CODE_CMD_REJECT;
          resStep = `STEP_BEFORE;
        end
      end
      ST_START: begin
        if (busReset) begin
          resPush = 1'b1; // R1
          resCode = `CODE_BUS_RESET;
          resStep = `STEP_BEFORE;
        end else if (transferByteCount == 8'h00) begin
          resPush = 1'b1; // R8
          resCode = `CODE_CMD_REJECT;
          resStep = `STEP_DURING;
        end
      end
      ST_XFER, ST_AUTOMSG: begin
        if (busReset) begin
          resPush = 1'b1; // R1
          resCode = `CODE_BUS_RESET;
          resStep = (state_q == ST_XFER) ? `STEP_DURING : `STEP_AFTER;
        end else if (timeoutHit) begin
          resPush = 1'b1; // R2
          resCode = `CODE_HS_TIMEOUT;
          resStep = `STEP_DURING;
        end else if (byteStrobe && byteParityErr) begin
          resPush = 1'b1; // R3
          resCode = `CODE_SCSI_PARITY;
          resStep = `STEP_DURING;
        end else if (byteStrobe && state_q == ST_AUTOMSG) begin
          resPush = 1'b1; // R6
          resCode = `CODE_DONE_ATN_MSG;
          resStep = `STEP_AFTER;
        end
      end
      ST_DONE: begin
        if (busReset) begin
          resPush = 1'b1; // R1
          resCode = `CODE_BUS_RESET;
          resStep = `STEP_AFTER;
        end else if (!atnAsserted) begin
          resPush = 1'b1; // R4
          resCode = `CODE_DONE;
          resStep = `STEP_AFTER;
        end else if (!(isCmd_q && autoMsgMode)) begin
          resPush = 1'b1; // R5 R7
          resCode = `CODE_DONE_ATN;
          resStep = `STEP_AFTER;
        end
      end
      default: begin
        resPush = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Receive sequencer
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      state_q <= ST_IDLE;
      isCmd_q <= 1'b0;
      cnt_q <= `RESET_BYTE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (cmdValid && !cmdDefer && !cmdParityErr &&
              (cmdClass == CLS_RECV_CMD || cmdClass == CLS_RECV_MSG)) begin
            state_q <= ST_START;
            isCmd_q <= (cmdClass == CLS_RECV_CMD);
          end
        end
        ST_START: begin
          cnt_q <= transferByteCount;
          state_q <= resPush ? ST_IDLE : ST_XFER; // R8
        end
        ST_XFER: begin
          if (resPush) begin
            state_q <= ST_IDLE; // R2 R3
          end else if (byteStrobe) begin
            cnt_q <= cnt_q - 8'h01;
            if (cnt_q == 8'h01) begin
              state_q <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          state_q <= resPush ? ST_IDLE : ST_AUTOMSG; // R6
        end
        ST_AUTOMSG: begin
          if (resPush) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Status outputs for the transfer engine and other sequencers
  always_ff @(posedge sys_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      rxActive_q <= 1'b0;
      forwardValid_q <= 1'b0;
      forwardCode_q <= `RESET_BYTE;
    end else begin
      // Drops on the same edge that ends the receive, so the far side stops at once
      rxActive_q <= (state_q != ST_IDLE) && !resPush;
      forwardValid_q <= (state_q == ST_IDLE) && cmdValid && !cmdDefer && !cmdParityErr &&
                        (cmdClass == CLS_FORWARD);
      if (cmdValid && !cmdDefer) begin
        forwardCode_q <= cmdCode;
      end
    end
  end

  // ----------------------------------------
  // Deferred command and ready-state causes
  // ----------------------------------------
  // Only leaves once the earlier result is already queued ahead of it
  assign push64 = defer64_q && !resPush && !readyPushNow && state_q == ST_IDLE; // R9 R10

  // Set wins over the clear so a deferral in the cycle of the push is not lost
  always_ff @(posedge sys_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      defer64_q <= 1'b0;
    end else if (cmdDefer) begin
      defer64_q <= 1'b1; // R9 R10
    end else if (push64) begin
      defer64_q <= 1'b0;
    end
  end

  // One-entry hold; a second cause during a busy cycle overwrites it
  assign readyPushNow = (readyHold_q || readyCause) && !resPush;
  always_ff @(posedge sys_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      readyHold_q <= 1'b0;
      readyHoldData_q <= 16'h0000;
    end else if (readyCause && (resPush || readyHold_q)) begin
      readyHold_q <= 1'b1;
      readyHoldData_q <= {readyCauseCode, readyCauseStep};
    end else if (readyPushNow) begin
      readyHold_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Report queue and interrupt
  // ----------------------------------------
  assign pushValid = resPush || readyPushNow || push64;
  assign pushData = resPush ? {resCode, resStep} :
                    readyPushNow ? (readyHold_q ? readyHoldData_q : {readyCauseCode, readyCauseStep}) :
                    {`CODE_CMD_DEFERRED, `STEP_BEFORE};

  report_queue #(
    .WIDTH(16),
    .DEPTH(QUEUE_DEPTH)
  ) u_queue (
    .clk(sys_clk),
    .rstnInt(rstnInt),
    .push(pushValid),
    .pushData(pushData),
    .pop(!intReq_q && qNotEmpty),
    .headData(headData),
    .notEmpty(qNotEmpty),
    .full()
  );

  // Pair stays put until acknowledged, then the next one is posted
  always_ff @(posedge sys_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      intReq_q <= 1'b0;
      intCode_q <= `RESET_BYTE;
      intStep_q <= `RESET_BYTE;
    end else if (!intReq_q && qNotEmpty) begin
      intReq_q <= 1'b1; // R14
      intCode_q <= headData[15:8];
      intStep_q <= headData[7:0];
    end else if (intReq_q && intAck) begin
      intReq_q <= 1'b0;
    end
  end

  assign intReq = intReq_q;
  assign intCode = intCode_q;
  assign intStep = intStep_q;
  assign rxActive = rxActive_q;
  assign forwardValid = forwardValid_q;
  assign forwardCode = forwardCode_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_reset_during: assert property (@(posedge sys_clk) disable iff (!rstnInt) // R1
    state_q == ST_XFER && busReset |-> resPush && resCode == 8'h01 && resStep == 8'h01 ##1 state_q == ST_IDLE)
    else $error("bus reset during transfer misreported");
  a_timeout_end: assert property (@(posedge sys_clk) disable iff (!rstnInt) // R2
    state_q == ST_XFER && !busReset && timeoutHit |-> resCode == 8'h2c ##1 state_q == ST_IDLE && !rxActive_q)
    else $error("timeout did not end receive");
  a_parity_end: assert property (@(posedge sys_clk) disable iff (!rstnInt) // R3
    state_q == ST_XFER && !busReset && !timeoutHit && byteStrobe && byteParityErr
    |-> resCode == 8'h24 && resStep == 8'h01 ##1 state_q == ST_IDLE)
    else $error("parity error did not end receive");
  a_normal_done: assert property (@(posedge sys_clk) disable iff (!rstnInt) // R4
    state_q == ST_DONE && !busReset && !atnAsserted |-> resPush && resCode == 8'h60 && resStep == 8'h02)
    else $error("normal completion misreported");
  a_atn_plain: assert property (@(posedge sys_clk) disable iff (!rstnInt) // R5
    state_q == ST_DONE && !busReset && atnAsserted && isCmd_q && !autoMsgMode |-> resCode == 8'h61)
    else $error("attention without auto mode misreported");
  a_atn_auto: assert property (@(posedge sys_clk) disable iff (!rstnInt) // R6
    state_q == ST_DONE && !busReset && atnAsserted && isCmd_q && autoMsgMode |-> !resPush ##1 state_q == ST_AUTOMSG)
    else $error("auto message byte not taken");
  a_msg_atn: assert property (@(posedge sys_clk) disable iff (!rstnInt) // R7
    state_q == ST_DONE && !busReset && atnAsserted && !isCmd_q |-> resCode == 8'h61 && resStep == 8'h02)
    else $error("message receive attention misreported");
  a_zero_count: assert property (@(posedge sys_clk) disable iff (!rstnInt) // R8
    state_q == ST_START && !busReset && transferByteCount == 8'h00
    |-> resCode == 8'h65 && resStep == 8'h01 ##1 state_q == ST_IDLE)
    else $error("zero byte count started a transfer");
  a_double_rx: assert property (@(posedge sys_clk) disable iff (!rstnInt) // R9
    cmdValid && state_q != ST_IDLE |=> defer64_q && state_q != ST_START && !forwardValid_q)
    else $error("double reception not deferred");
  a_reject_cmd: assert property (@(posedge sys_clk) disable iff (!rstnInt) // R11
    state_q == ST_IDLE && cmdValid && !pending && !cmdParityErr && cmdClass == CLS_REJECT
    |-> resCode == 8'h65 && resStep == 8'h00 ##1 state_q == ST_IDLE)
    else $error("illegal command not rejected");
  a_reg_parity: assert property (@(posedge sys_clk) disable iff (!rstnInt) // R13
    state_q == ST_IDLE && cmdValid && !pending && cmdParityErr |-> resCode == 8'h66 ##1 state_q == ST_IDLE)
    else $error("register parity error ignored");
  a_int_hold: assert property (@(posedge sys_clk) disable iff (!rstnInt) // R14
    intReq_q && !intAck |=> intReq_q && $stable(intCode_q) && $stable(intStep_q))
    else $error("posted report changed before acknowledge");

endmodule

// file: sim/initiator_model.sv
module initiator_model (
  input wire logic sys_clk,
  input wire logic rxActive,
  input wire logic [7:0] count,
  input wire logic extra,
  input wire logic stall,
  input wire logic [7:0] parAt,
  output logic byteStrobe,
  output logic byteParityErr,
  output logic sentAll
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prevActive = 1'b0;
  logic running = 1'b0;
  logic junk = 1'b0;
  logic [7:0] sent = 8'h00;
  logic [4:0] timer = 5'h00;

  initial begin
    byteStrobe = 1'b0;
    byteParityErr = 1'b0;
    sentAll = 1'b0;
  end

  // Byte source; parity line toggles between bytes since it means nothing then
  always @(negedge sys_clk) begin
    byteStrobe <= 1'b0;
    junk <= ~junk;
    byteParityErr <= ~junk;
    if (rxActive && !prevActive) begin
      running <= 1'b1;
      sent <= 8'h00;
      timer <= 5'h03;
      sentAll <= 1'b0;
    end else if (running && !rxActive && sent < count) begin
      running <= 1'b0; // Receive ended early, stop sending
    end else if (running && !stall) begin
      if (timer != 5'h00) begin
        timer <= timer - 5'h01;
      end else begin
        byteStrobe <= 1'b1;
        byteParityErr <= (sent + 8'h01 == parAt);
        sent <= sent + 8'h01;
        // Long gap before the trailing message byte
        timer <= (sent + 8'h01 == count) ? 5'h14 : 5'h03;
        if (sent + 8'h01 == count) sentAll <= 1'b1;
        if (sent + 8'h01 >= count + {7'h00, extra}) running <= 1'b0;
      end
    end
    prevActive <= rxActive;
  end
endmodule

// file: sim/target_receive_status_reporter_test.sv
module target_receive_status_reporter_test;
  import target_status_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] cnt;
    logic atn;
    logic autoOn;
    logic nex;
    logic stl;
    logic [7:0] par;
    logic [7:0] code;
    logic [7:0] step;
  } row_type;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic cmdValid = 1'b0;
  logic [7:0] cmdCode = 8'h00;
  logic cmdParityErr = 1'b0;
  logic isTarget = 1'b1;
  logic nexusValid = 1'b1;
  logic [7:0] transferByteCount = 8'h00;
  logic autoMsgMode = 1'b0;
  logic [7:0] timeoutLimit = 8'h00;
  logic busReset = 1'b0;
  logic atnAsserted = 1'b0;
  logic readyCause = 1'b0;
  logic [7:0] readyCauseCode = 8'h00;
  logic [7:0] readyCauseStep = 8'h00;
  logic intAck = 1'b0;
  logic extra = 1'b0;
  logic stall = 1'b0;
  logic [7:0] parAt = 8'h00;
  logic byteStrobe, byteParityErr, sentAll, intReq, rxActive, forwardValid;
  logic [7:0] intCode, intStep, forwardCode;
  int err_total = 0;
  int n_checks = 0;
  int cycles = 0;
  int w;
  row_type rows [14];

  // ----------------------------------------
  // Clock, instances, watchdog
  // ----------------------------------------
  always #5 sys_clk = ~sys_clk;

  target_receive_status_reporter target_receive_status_reporter_inst (
    .sys_clk(sys_clk), .rstn(rstn), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdParityErr(cmdParityErr), .isTarget(isTarget), .nexusValid(nexusValid),
    .transferByteCount(transferByteCount), .autoMsgMode(autoMsgMode),
    .timeoutLimit(timeoutLimit), .busReset(busReset), .atnAsserted(atnAsserted),
    .byteStrobe(byteStrobe), .byteParityErr(byteParityErr), .readyCause(readyCause),
    .readyCauseCode(readyCauseCode), .readyCauseStep(readyCauseStep), .intAck(intAck),
    .intReq(intReq), .intCode(intCode), .intStep(intStep), .rxActive(rxActive),
    .forwardValid(forwardValid), .forwardCode(forwardCode));

  initiator_model initiator_model_inst (
    .sys_clk(sys_clk), .rxActive(rxActive), .count(transferByteCount), .extra(extra),
    .stall(stall), .parAt(parAt), .byteStrobe(byteStrobe),
    .byteParityErr(byteParityErr), .sentAll(sentAll));

  // Cut a hang short well past the expected run length
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      conclude();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic issue(input logic [7:0] code);
    @(negedge sys_clk);
    cmdValid = 1'b1;
    cmdCode = code;
    @(negedge sys_clk);
    cmdValid = 1'b0;
  endtask

  // Wait for a posted pair, compare it, then acknowledge
  task automatic takeReport(input logic [7:0] code, input logic [7:0] step);
    for (w = 0; w < 400 && intReq !== 1'b1; w++) @(negedge sys_clk);
    chk({7'h00, intReq}, 8'h01);
    chk(intCode, code);
    chk(intStep, step);
    intAck = 1'b1;
    @(negedge sys_clk);
    intAck = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic setup(input logic [7:0] c, input logic a, input logic m, input logic x);
    transferByteCount = c;
    atnAsserted = a;
    autoMsgMode = m;
    extra = x;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rows = '{
      '{8'h14, 8'h02, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 8'h60, 8'h02},
      '{8'h15, 8'h03, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 8'h60, 8'h02},
      '{8'h14, 8'h02, 1'b1, 1'b0, 1'b1, 1'b0, 8'h00, 8'h61, 8'h02},
      '{8'h14, 8'h02, 1'b1, 1'b1, 1'b1, 1'b0, 8'h00, 8'h62, 8'h02},
      '{8'h15, 8'h02, 1'b1, 1'b0, 1'b1, 1'b0, 8'h00, 8'h61, 8'h02},
      '{8'h15, 8'h02, 1'b1, 1'b1, 1'b1, 1'b0, 8'h00, 8'h61, 8'h02},
      '{8'h14, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 8'h65, 8'h01},
      '{8'h15, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 8'h65, 8'h01},
      '{8'h15, 8'h03, 1'b0, 1'b0, 1'b1, 1'b0, 8'h02, 8'h24, 8'h01},
      '{8'h14, 8'h02, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00, 8'h2c, 8'h01},
      '{8'h20, 8'h02, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 8'h65, 8'h00},
      '{8'h33, 8'h02, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 8'h65, 8'h00},
      '{8'h14, 8'h02, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h65, 8'h00},
      '{8'h10, 8'h02, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 8'h65, 8'h00}};
    repeat (2) @(negedge sys_clk);
    chk({7'h00, intReq}, 8'h00);
    chk(intCode, 8'h00);
    chk(intStep, 8'h00);
    chk({7'h00, rxActive}, 8'h00);
    chk({7'h00, forwardValid}, 8'h00);
    chk(forwardCode, 8'h00);
    rstn = 1'b1;
    repeat (3) @(negedge sys_clk);
    // Table of ordinary outcomes; timeout of one tick when the initiator stalls
    foreach (rows[i]) begin
      setup(rows[i].cnt, rows[i].atn, rows[i].autoOn, rows[i].atn & rows[i].autoOn & (rows[i].cmd == 8'h14));
      nexusValid = rows[i].nex;
      stall = rows[i].stl;
      parAt = rows[i].par;
      timeoutLimit = rows[i].stl ? 8'h01 : 8'h00;
      issue(rows[i].cmd);
      takeReport(rows[i].code, rows[i].step);
      repeat (30) @(negedge sys_clk);
    end
    nexusValid = 1'b1;
    stall = 1'b0;
    parAt = 8'h00;
    timeoutLimit = 8'h00;
    // Bus reset before, during and after the transfer
    setup(8'h02, 1'b0, 1'b0, 1'b0);
    busReset = 1'b1;
    issue(8'h14);
    takeReport(8'h01, 8'h00);
    busReset = 1'b0;
    setup(8'h03, 1'b0, 1'b0, 1'b0);
    issue(8'h14);
    for (w = 0; w < 50 && rxActive !== 1'b1; w++) @(negedge sys_clk);
    busReset = 1'b1;
    takeReport(8'h01, 8'h01);
    busReset = 1'b0;
    repeat (30) @(negedge sys_clk);
    setup(8'h01, 1'b1, 1'b1, 1'b1);
    issue(8'h14);
    for (w = 0; w < 100 && sentAll !== 1'b1; w++) @(posedge sys_clk);
    repeat (4) @(negedge sys_clk);
    busReset = 1'b1;
    takeReport(8'h01, 8'h02);
    busReset = 1'b0;
    repeat (30) @(negedge sys_clk);
    // Back-to-back commands: first result, then the deferral
    setup(8'h02, 1'b0, 1'b0, 1'b0);
    issue(8'h14);
    issue(8'h18);
    takeReport(8'h60, 8'h02);
    takeReport(8'h64, 8'h00);
    // Ready-state cause in the same cycle as a command
    @(negedge sys_clk);
    readyCause = 1'b1;
    readyCauseCode = 8'h42;
    readyCauseStep = 8'h07;
    cmdValid = 1'b1;
    cmdCode = 8'h14;
    @(negedge sys_clk);
    readyCause = 1'b0;
    cmdValid = 1'b0;
    takeReport(8'h42, 8'h07);
    takeReport(8'h64, 8'h00);
    // Host register parity; the pair must still stand after a delay
    @(negedge sys_clk);
    cmdValid = 1'b1;
    cmdParityErr = 1'b1;
    @(negedge sys_clk);
    cmdValid = 1'b0;
    cmdParityErr = 1'b0;
    repeat (8) @(negedge sys_clk);
    takeReport(8'h66, 8'h00);
    chk({7'h00, rxActive}, 8'h00);
    // Legal command handled elsewhere posts nothing here
    issue(8'h16);
    chk({7'h00, forwardValid}, 8'h01);
    repeat (3) @(negedge sys_clk);
    chk({7'h00, forwardValid}, 8'h00);
    chk(forwardCode, 8'h16);
    chk({7'h00, intReq}, 8'h00);
    // Mid-run reset clears a posted pair at once, without waiting for a clock
    issue(8'h33);
    repeat (3) @(negedge sys_clk);
    chk({7'h00, intReq}, 8'h01);
    rstn = 1'b0;
    #1;
    chk({7'h00, intReq}, 8'h00);
    chk(intCode, 8'h00);
    chk(intStep, 8'h00);
    @(negedge sys_clk);
    rstn = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk({7'h00, intReq}, 8'h00);
    chk({7'h00, rxActive}, 8'h00);
    conclude();
  end
endmodule
